// *** wake_event_defines.vh ***
/*
  Constants of the wake packet event logic: register indices, field positions,
  reset values and wake pulse lengths.
  Assumes a Wishbone slave that puts each 16-bit register in the low half of one
  aligned 32-bit word, at a byte address of four times the register index.
*/
// How it works
// - Bit 8 of the filter configuration picks the wake output style: 0 gives a pulse, 1 a level.
// - In pulse style the wake output stays high for 8, 16, 32 or 64 cycles per the length code.
// - In level style the wake output stays high until software writes a one to bit 11.
// - With bit 4 set, a received unicast frame raises a wake event.
// - With bit 2 set, a received broadcast frame raises a wake event.
// - With bit 1 set, a frame matching the configured pattern raises a wake event.
// - With bit 0 set, a received magic packet raises a wake event.
// - Magic, pattern, broadcast and unicast flags sit at bits 0, 1, 2, 4 and clear on read.
// - Bad CRC sets flag bit 6 and a delimiter error sets flag bit 7; both clear on read.
// - The filter configuration resets to 1000h and its reserved bit 12 is kept as written.
`ifndef WAKE_EVENT_DEFINES_VH
`define WAKE_EVENT_DEFINES_VH

`define RX_FILTER_CONFIG_INDEX 10'h134
`define RX_FILTER_FLAGS_INDEX 10'h135
`define WAKE_IRQ_STATUS_INDEX 10'h136
`define WAKE_IRQ_MASK_INDEX 10'h137

`define RX_FILTER_CONFIG_RESET 16'h1000
`define RX_FILTER_CONFIG_STORED 16'hF7FF
`define FLAG_RESET 8'h00
`define FLAG_VALID 8'hD7
`define FLAG_WIDTH 8

`define CFG_MAGIC_WAKE_BIT 0
`define CFG_PATTERN_WAKE_BIT 1
`define CFG_BROADCAST_WAKE_BIT 2
`define CFG_UNICAST_WAKE_BIT 4
`define CFG_EXTENDED_RX_BIT 7
`define CFG_OUTPUT_STYLE_BIT 8
`define CFG_PULSE_LENGTH_LSB 9
`define CFG_PULSE_LENGTH_MSB 10
`define CFG_OUTPUT_CLEAR_BIT 11

`define FLAG_MAGIC_BIT 0
`define FLAG_PATTERN_BIT 1
`define FLAG_BROADCAST_BIT 2
`define FLAG_UNICAST_BIT 4
`define FLAG_BAD_CRC_BIT 6
`define FLAG_DELIMITER_ERR_BIT 7

`define WAKE_PULSE_BASE_CYCLES 7'h08
`define WAKE_COUNT_WIDTH 7

`endif

// *** event_flag_bank.v ***
/*
  Bank of sticky event flags.
  Assumes set and clear are single-cycle requests in the clk_i domain.
*/
`timescale 1ns/1ps
`default_nettype none

module event_flag_bank #(
  parameter WIDTH = 8
) (
  input wire clk_i,
  input wire rst_i,
  input wire [WIDTH-1:0] set_i,
  input wire [WIDTH-1:0] clear_i,
  output reg [WIDTH-1:0] flags_o
);

  // A set in the clearing cycle survives, so no event is lost to a read
  always @(posedge clk_i)
  begin
    if (rst_i)
    begin
      flags_o <= {WIDTH{1'b0}};
    end
    else
    begin
      flags_o <= (flags_o & ~clear_i) | set_i;
    end
  end

endmodule // event_flag_bank

`default_nettype wire

// *** wake_pulse_stretch.v ***
/*
  Stretches a one-cycle wake request into a pulse of 8, 16, 32 or 64 cycles.
  Assumes the length code is stable while a pulse runs; a new request restarts it.
*/
`timescale 1ns/1ps
`default_nettype none
`include "wake_event_defines.vh"

module wake_pulse_stretch (
  input wire clk_i,
  input wire rst_i,
  input wire fire_i,
  input wire [1:0] length_code_i,
  output reg active_o
);

  reg [`WAKE_COUNT_WIDTH-1:0] remaining;
  wire [`WAKE_COUNT_WIDTH-1:0] load_value;

  assign load_value = (`WAKE_PULSE_BASE_CYCLES << length_code_i) - 7'h01;

  always @(posedge clk_i)
  begin
    if (rst_i)
    begin
      active_o <= 1'b0;
      remaining <= 7'h00;
    end
    else if (fire_i)
    begin
      active_o <= 1'b1;
      remaining <= load_value;
    end
    else if (active_o)
    begin
      if (remaining == 7'h00)
      begin
        active_o <= 1'b0;
      end
      else
      begin
        remaining <= remaining - 7'h01;
      end
    end
  end

endmodule // wake_pulse_stretch

`default_nettype wire

// *** wake_packet_event_logic.v ***
/*
  Wake packet event logic: receive filter configuration and flags, interrupt status and
  mask, and the wake output in pulse or level style, behind a classic Wishbone slave.
  Assumes the receive datapath gives one-cycle classification pulses in clk_i, and a
  single-cycle Wishbone master that holds each request until it sees ack_o.
*/
// Implementation choice: the Wishbone register port.
`timescale 1ns/1ps
`default_nettype none
`include "wake_event_defines.vh"

module wake_packet_event_logic (
  input wire clk_i,
  input wire rst_i,
  input wire cyc_i,
  input wire stb_i,
  input wire we_i,
  input wire [11:0] adr_i,
  input wire [3:0] sel_i,
  input wire [31:0] dat_i,
  output reg [31:0] dat_o,
  output reg ack_o,
  input wire rx_magic_i,
  input wire rx_pattern_i,
  input wire rx_broadcast_i,
  input wire rx_unicast_i,
  input wire rx_bad_crc_i,
  input wire rx_delimiter_err_i,
  output reg extended_rx_features_enable_o,
  output reg wake_o,
  output reg irq_o
);

  // Byte lanes 0 and 1 carry the 16-bit registers; lanes 2 and 3 are ignored
  function [15:0] lane_mask;
    input [3:0] sel;
    begin
      lane_mask = {{8{sel[1]}}, {8{sel[0]}}};
    end
  endfunction

  function [15:0] merge_write;
    input [15:0] old_value;
    input [15:0] new_value;
    input [15:0] enable;
    begin
      merge_write = (old_value & ~enable) | (new_value & enable);
    end
  endfunction

  // One compare shared by every register select
  function reg_hit;
    input [9:0] index;
    input [9:0] target;
    begin
      reg_hit = (index == target);
    end
  endfunction

  reg [15:0] rx_filter_config;
  reg [7:0] wake_irq_mask;
  reg wake_level;
  reg [`FLAG_WIDTH-1:0] rx_events;
  reg [`FLAG_WIDTH-1:0] flags_clear;
  reg [`FLAG_WIDTH-1:0] irq_clear;
  reg [15:0] next_config;
  reg [7:0] next_mask;
  reg [31:0] next_dat;
  reg next_wake;
  reg next_level;
  reg next_irq;
  wire [`FLAG_WIDTH-1:0] rx_filter_flags;
  wire [`FLAG_WIDTH-1:0] wake_irq_status;
  wire bus_request;
  wire bus_write;
  wire bus_read;
  wire [9:0] reg_index;
  wire hit_config;
  wire hit_flags;
  wire hit_irq_status;
  wire hit_irq_mask;
  wire output_style_level;
  wire [1:0] pulse_length_code;
  wire wake_output_clear;
  wire wake_event;
  wire pulse_active;

  // Classic Wishbone: one request is taken per handshake, ack_o masks the repeat
  assign bus_request = cyc_i & stb_i & ~ack_o;
  assign bus_write = bus_request & we_i;
  assign bus_read = bus_request & ~we_i;
  assign reg_index = adr_i[11:2];
  assign hit_config = reg_hit(reg_index, `RX_FILTER_CONFIG_INDEX);
  assign hit_flags = reg_hit(reg_index, `RX_FILTER_FLAGS_INDEX);
  assign hit_irq_status = reg_hit(reg_index, `WAKE_IRQ_STATUS_INDEX);
  assign hit_irq_mask = reg_hit(reg_index, `WAKE_IRQ_MASK_INDEX);

  assign output_style_level = rx_filter_config[`CFG_OUTPUT_STYLE_BIT];
  assign pulse_length_code =
    rx_filter_config[`CFG_PULSE_LENGTH_MSB:`CFG_PULSE_LENGTH_LSB];

  // The clear bit acts on the write itself and never stores
  assign wake_output_clear = bus_write & hit_config & sel_i[1]
    & dat_i[`CFG_OUTPUT_CLEAR_BIT];

  // Gather the receive classification into the flag layout
  always @*
  begin
    rx_events = `FLAG_RESET;
    rx_events[`FLAG_MAGIC_BIT] = rx_magic_i;
    rx_events[`FLAG_PATTERN_BIT] = rx_pattern_i;
    rx_events[`FLAG_BROADCAST_BIT] = rx_broadcast_i;
    rx_events[`FLAG_UNICAST_BIT] = rx_unicast_i;
    rx_events[`FLAG_BAD_CRC_BIT] = rx_bad_crc_i;
    rx_events[`FLAG_DELIMITER_ERR_BIT] = rx_delimiter_err_i;
  end

  // Error flags never wake the host; only enabled frame classes do
  assign wake_event =
    (rx_magic_i & rx_filter_config[`CFG_MAGIC_WAKE_BIT])
    | (rx_pattern_i & rx_filter_config[`CFG_PATTERN_WAKE_BIT])
    | (rx_broadcast_i & rx_filter_config[`CFG_BROADCAST_WAKE_BIT])
    | (rx_unicast_i & rx_filter_config[`CFG_UNICAST_WAKE_BIT]);

  // A read of the flag register empties it; events of that cycle stay set
  always @*
  begin
    flags_clear = `FLAG_RESET;
    if (bus_read && hit_flags)
    begin
      flags_clear = {`FLAG_WIDTH{1'b1}};
    end
  end

  always @*
  begin
    irq_clear = `FLAG_RESET;
    if (bus_write && hit_irq_status && sel_i[0])
    begin
      irq_clear = dat_i[7:0];
    end
  end

  event_flag_bank #(
    .WIDTH(`FLAG_WIDTH)
  ) u_rx_flags (
    .clk_i(clk_i),
    .rst_i(rst_i),
    .set_i(rx_events),
    .clear_i(flags_clear),
    .flags_o(rx_filter_flags)
  );

  event_flag_bank #(
    .WIDTH(`FLAG_WIDTH)
  ) u_irq_flags (
    .clk_i(clk_i),
    .rst_i(rst_i),
    .set_i(rx_events),
    .clear_i(irq_clear),
    .flags_o(wake_irq_status)
  );

  wake_pulse_stretch u_pulse (
    .clk_i(clk_i),
    .rst_i(rst_i),
    .fire_i(wake_event & ~output_style_level),
    .length_code_i(pulse_length_code),
    .active_o(pulse_active)
  );

  // Reserved bits keep what software writes, including the bit that resets to one
  always @*
  begin
    next_config = rx_filter_config;
    if (bus_write && hit_config)
    begin
      next_config = merge_write(rx_filter_config, dat_i[15:0],
        lane_mask(sel_i) & `RX_FILTER_CONFIG_STORED);
    end
  end

  always @*
  begin
    next_mask = wake_irq_mask;
    if (bus_write && hit_irq_mask && sel_i[0])
    begin
      next_mask = dat_i[7:0];
    end
  end

  // Leaving level style drops a pending level so a later switch starts clean
  always @*
  begin
    next_level = 1'b0;
    if (output_style_level)
    begin
      next_level = (wake_level & ~wake_output_clear) | wake_event;
    end
  end

  always @*
  begin
    if (output_style_level)
    begin
      next_wake = wake_level;
    end
    else
    begin
      next_wake = pulse_active;
    end
  end

  // Read data is captured with the request; the flags show their value before clearing
  always @*
  begin
    next_dat = 32'h00000000;
    if (bus_read)
    begin
      if (hit_config)
      begin
        next_dat[15:0] = rx_filter_config;
      end
      else if (hit_flags)
      begin
        next_dat[7:0] = rx_filter_flags & `FLAG_VALID;
      end
      else if (hit_irq_status)
      begin
        next_dat[7:0] = wake_irq_status & `FLAG_VALID;
      end
      else if (hit_irq_mask)
      begin
        next_dat[7:0] = wake_irq_mask;
      end
      else
      begin
        next_dat = 32'h00000000;
      end
    end
  end

  always @(posedge clk_i)
  begin
    if (rst_i)
    begin
      rx_filter_config <= `RX_FILTER_CONFIG_RESET;
    end
    else
    begin
      rx_filter_config <= next_config;
    end
  end

  always @(posedge clk_i)
  begin
    if (rst_i)
    begin
      wake_irq_mask <= `FLAG_RESET;
    end
    else
    begin
      wake_irq_mask <= next_mask;
    end
  end

  always @(posedge clk_i)
  begin
    if (rst_i)
    begin
      wake_level <= 1'b0;
    end
    else
    begin
      wake_level <= next_level;
    end
  end

  // Unmapped addresses still get an ack so the master never hangs
  always @(posedge clk_i)
  begin
    if (rst_i)
    begin
      ack_o <= 1'b0;
    end
    else
    begin
      ack_o <= bus_request;
    end
  end

  always @(posedge clk_i)
  begin
    if (rst_i)
    begin
      dat_o <= 32'h00000000;
    end
    else
    begin
      dat_o <= next_dat;
    end
  end

  always @*
  begin
    next_irq = |(wake_irq_status & wake_irq_mask & `FLAG_VALID);
  end

  always @(posedge clk_i)
  begin
    if (rst_i)
    begin
      wake_o <= 1'b0;
    end
    else
    begin
      wake_o <= next_wake;
    end
  end

  always @(posedge clk_i)
  begin
    if (rst_i)
    begin
      irq_o <= 1'b0;
    end
    else
    begin
      irq_o <= next_irq;
    end
  end

  always @(posedge clk_i)
  begin
    if (rst_i)
    begin
      extended_rx_features_enable_o <= 1'b0;
    end
    else
    begin
      extended_rx_features_enable_o <= rx_filter_config[`CFG_EXTENDED_RX_BIT];
    end
  end

endmodule // wake_packet_event_logic

`default_nettype wire

// *** wake_event_props.sv ***
/*
  Concurrent checks on the ports of the wake packet event logic.
  Assumes it is bound to wake_packet_event_logic and sees only its ports.
*/
`timescale 1ns/1ps
`default_nettype none
`include "wake_event_defines.vh"

module wake_event_props (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic cyc_i,
  input wire logic stb_i,
  input wire logic we_i,
  input wire logic [11:0] adr_i,
  input wire logic [3:0] sel_i,
  input wire logic [31:0] dat_i,
  input wire logic ack_o,
  input wire logic rx_magic_i,
  input wire logic rx_pattern_i,
  input wire logic rx_broadcast_i,
  input wire logic rx_unicast_i,
  input wire logic extended_rx_features_enable_o,
  input wire logic wake_o,
  input wire logic irq_o
);
  logic [10:0] cfg;
  logic [15:0] cnt;
  wire take = cyc_i && stb_i && !ack_o && we_i && adr_i[11:2] == `RX_FILTER_CONFIG_INDEX;
  wire clr = take && sel_i[1] && dat_i[11];
  wire ev_en = |({rx_unicast_i, rx_broadcast_i, rx_pattern_i, rx_magic_i} & {cfg[4], cfg[2:0]});

  // Shadow of the config fields, so timing is judged without seeing the body
  always @(posedge clk_i)
  begin
    if (rst_i)
    begin
      cfg <= 11'h000;
      cnt <= 16'h0000;
    end
    else
    begin
      if (take && sel_i[0])
        cfg[7:0] <= dat_i[7:0];
      if (take && sel_i[1])
        cfg[10:8] <= dat_i[10:8];
      cnt <= wake_o ? cnt + 16'h0001 : 16'h0000;
    end
  end

  default clocking @(posedge clk_i); endclocking
  default disable iff (rst_i);

  ack_one_cycle_a: assert property (ack_o |=> !ack_o)
    else $error("ack longer than one cycle");
  ack_answer_a: assert property (cyc_i && stb_i && !ack_o |=> ack_o)
    else $error("request not answered");
  reset_quiet_a: assert property ($past(rst_i) |-> !ack_o && !wake_o && !irq_o)
    else $error("outputs not quiet after reset");
  wake_on_event_a: assert property (ev_en |-> ##2 wake_o)
    else $error("enabled event gave no wake");
  wake_cause_a: assert property ($rose(wake_o) |-> $past(ev_en, 2))
    else $error("wake without enabled event");
  pulse_length_a: assert property ($fell(wake_o) && !cfg[8] |-> cnt >= (16'h0008 << cfg[10:9]))
    else $error("wake pulse too short");
  level_clear_a: assert property ($fell(wake_o) && cfg[8] |-> $past(clr, 2) || $past(clr, 3))
    else $error("level wake fell without clear");
  ext_copy_a: assert property (extended_rx_features_enable_o == $past(cfg[7]))
    else $error("extended enable output wrong");

  cover property ($fell(wake_o) && !cfg[8]);
  cover property ($fell(wake_o) && cfg[8]);
  cover property ($rose(irq_o));
endmodule // wake_event_props

bind wake_packet_event_logic wake_event_props props (.clk_i, .rst_i, .cyc_i, .stb_i, .we_i,
  .adr_i, .sel_i, .dat_i, .ack_o, .rx_magic_i, .rx_pattern_i, .rx_broadcast_i, .rx_unicast_i,
  .extended_rx_features_enable_o, .wake_o, .irq_o);

`default_nettype wire

// *** wake_host_model.sv ***
/*
  Host side that samples the wake output: counts rising edges and the length of
  the last high run. Assumes the same clock as the block.
*/
`timescale 1ns/1ps
`default_nettype none

module wake_host_model (
  input wire logic clk_i,
  input wire logic wake_i,
  output var int last_len_o,
  output var int rises_o
);
  int run;

  initial
  begin
    run = 0;
    last_len_o = 0;
    rises_o = 0;
  end

  always @(posedge clk_i)
  begin
    if (wake_i)
    begin
      if (run == 0)
        rises_o <= rises_o + 1;
      run <= run + 1;
    end
    else
    begin
      if (run != 0)
        last_len_o <= run;
      run <= 0;
    end
  end
endmodule // wake_host_model

`default_nettype wire

// *** testbench.sv ***
/*
  Self-checking bench for the wake packet event logic with a register model.
  Assumes the design files and the host model are compiled before it.
*/
`timescale 1ns/1ps
`default_nettype none

module testbench;
  logic clk_i = 0, rst_i = 1, cyc_i = 0, stb_i = 0, we_i = 0;
  logic [11:0] adr_i = 12'h000;
  logic [3:0] sel_i = 4'h0;
  logic [31:0] dat_i = 32'h00000000;
  logic [5:0] rx = 6'h00;
  logic [31:0] q;
  wire [31:0] dat_o;
  wire ack_o, ext_o, wake_o, irq_o;
  int num_errors = 0, n_tests = 0, cycles = 0, seed = 41531;
  int k, b, r, last_len, rises, cfg_m, flags_m, st_m;

  always #2.5 clk_i = ~clk_i;

  wake_packet_event_logic dut (.clk_i(clk_i), .rst_i(rst_i), .cyc_i(cyc_i), .stb_i(stb_i),
    .we_i(we_i), .adr_i(adr_i), .sel_i(sel_i), .dat_i(dat_i), .dat_o(dat_o), .ack_o(ack_o),
    .rx_magic_i(rx[0]), .rx_pattern_i(rx[1]), .rx_broadcast_i(rx[2]), .rx_unicast_i(rx[3]),
    .rx_bad_crc_i(rx[4]), .rx_delimiter_err_i(rx[5]), .extended_rx_features_enable_o(ext_o),
    .wake_o(wake_o), .irq_o(irq_o));
  wake_host_model host (.clk_i(clk_i), .wake_i(wake_o), .last_len_o(last_len), .rises_o(rises));

  task chk(input [31:0] got, input [31:0] exp);
    n_tests++;
    if (got !== exp)
    begin
      num_errors++;
      $display("unexpected at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  task end_sim;
    $display("errors %0d checks %0d", num_errors, n_tests);
    if (num_errors == 0 && n_tests > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask

  // Ack is looked at on the edge that ends its cycle, so no race with its update
  task automatic wb(input logic w, input [9:0] idx, input [31:0] d);
    cyc_i <= 1'b1;
    stb_i <= 1'b1;
    we_i <= w;
    adr_i <= {idx, 2'b00};
    sel_i <= 4'h3;
    dat_i <= d;
    // Only ack_o or the bench timeout ends this wait
    do @(posedge clk_i); while (ack_o !== 1'b1);
    q = dat_o;
    cyc_i <= 1'b0;
    stb_i <= 1'b0;
    we_i <= 1'b0;
    @(posedge clk_i);
  endtask

  task ev(input int i);
    b = (i < 3) ? i : (i == 3 ? 4 : i + 2);
    flags_m |= 1 << b;
    st_m |= 1 << b;
    rx <= 6'h01 << i;
    @(posedge clk_i);
    rx <= 6'h00;
    @(posedge clk_i);
  endtask

  always @(posedge clk_i)
  begin
    cycles++;
    if (cycles == 5000)
    begin
      num_errors++;
      end_sim;
    end
  end

  initial
  begin
    repeat (2) @(posedge clk_i);
    rst_i <= 1'b0;
    @(posedge clk_i);
    flags_m = 0;
    st_m = 0;
    wb(0, 10'h134, 0);
    chk(q, 32'h00001000);
    wb(0, 10'h135, 0);
    chk(q, 32'h00000000);
    chk(ext_o, 1'b0);
    wb(0, 10'h1FF, 0);
    chk(q, 32'h00000000);
    r = $unsigned($random(seed)) % 4;
    for (k = 0; k < 4; k++)
    begin
      cfg_m = 32'h1097 | (k << 9);
      wb(1, 10'h134, cfg_m | 32'h0800);
      wb(0, 10'h134, 0);
      chk(q, cfg_m);
      ev((k + r) % 4);
      repeat (80) @(posedge clk_i);
      chk(last_len, 8 << k);
    end
    chk(rises, 4);
    ev(4);
    ev(5);
    repeat (4) @(posedge clk_i);
    chk(rises, 4);
    wb(0, 10'h135, 0);
    chk(q, flags_m);
    flags_m = 0;
    wb(0, 10'h135, 0);
    chk(q, flags_m);
    cfg_m = 32'h1196;
    wb(1, 10'h134, cfg_m);
    ev(0);
    repeat (4) @(posedge clk_i);
    chk(wake_o, 1'b0);
    ev(3);
    repeat (100) @(posedge clk_i);
    chk(wake_o, 1'b1);
    wb(1, 10'h134, cfg_m | 32'h0800);
    repeat (3) @(posedge clk_i);
    chk(wake_o, 1'b0);
    chk(ext_o, 1'b1);
    wb(1, 10'h137, 32'h10);
    repeat (3) @(posedge clk_i);
    chk(irq_o, 1'b1);
    wb(1, 10'h136, 32'h10);
    st_m &= ~32'h10;
    repeat (2) @(posedge clk_i);
    chk(irq_o, 1'b0);
    wb(0, 10'h136, 0);
    chk(q, st_m);
    end_sim;
  end
endmodule // testbench

`default_nettype wire
